/* File: logic/macrocell_ctrl_output_routing.sv */
// Control steering around the 16 register cells of one logic block,
// its block clock generator, and its output routing pool.
// Assumes all pins and product terms arrive synchronous to aclk and
// that software loads configuration while the run bit is clear.
//
// Functional notes
// - Clock enable picks term, inverted term, shared clock, or high.
// - One block init term reaches every register cell.
// - Each cell may take set and reset from two own terms.
// - Swap option exchanges a cell's reset and preset sources.
// - The swap option also decides the power-up state.
// - Cells set by the block init term power up set.
// - Cells reset by it, or unconfigured, power up cleared.
// - Global clock pins are also offered as ordinary inputs.
// - A clock generator makes four block clocks for all cells.
// - Each block clock combines true or inverted global clocks.
// - A cell output can be routed to one of several I/O cells.
// - The local enable term travels beside the routed output.
// - One routing slice per I/O cell, with one select for data and enable.
// - Sixteen slices: slice k sees cells k to k+7, wrapping.
// - Eight slices: slice k sees cells 2k to 2k+7, wrapping.
// - Twelve slices start at 0,1,2,4,5,6,8,9,10,12,13,14.
// - Each slice delivers the enable of the cell its select chose.
// - Third cluster term serves as clock enable only, never as init.
// - Shared clock and shared init terms are optionally inverted.
`default_nettype none
`include "macrocell_map.svh"

module macrocell_ctrl_output_routing #(
	parameter int unsigned SLICES = 16
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Global clock pins
	input wire logic [3:0] gclk_pin,
	// Product terms from the array
	input wire logic [15:0] indiv_init_or_clk_en_term,
	input wire logic [15:0] indiv_set_term,
	input wire logic [15:0] indiv_reset_term,
	input wire logic [15:0] cell_oe_term,
	input wire logic shared_term_clock,
	input wire logic shared_term_init,
	input wire logic [15:0] cell_d,
	// Toward the global routing pool
	output logic [3:0] global_routing_pool_clk,
	output logic [15:0] cell_q,
	// Toward the I/O cells
	output logic [SLICES-1:0] io_out,
	output logic [SLICES-1:0] io_oe
);
	import macrocell_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Register bus

	logic aw_held, w_held, wr_fire;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic [31:0] ctrl_reg;
	logic [31:0] clkgen_reg;
	logic [31:0] sel_lo_reg;
	logic [31:0] sel_hi_reg;
	cell_cfg_t cell_cfg_reg [16];
	logic run;
	logic wr_locked, wr_is_cell, wr_known;

	// Merge write data into a word by byte strobes
	function automatic logic [31:0] merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] strb);
		logic [31:0] res;
		res = old_w;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = new_w[8*b +: 8];
			end
		end
		return res;
	endfunction

	assign run = ctrl_reg[`CTRL_RUN_BIT];
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;
	assign wr_is_cell = awaddr_reg[7:6] == `CELL_CFG_PAGE && awaddr_reg[1:0] == 2'h0;
	assign wr_known = wr_is_cell || awaddr_reg == `OFS_CTRL ||
		awaddr_reg == `OFS_CLKGEN || awaddr_reg == `OFS_SEL_LO ||
		awaddr_reg == `OFS_SEL_HI;
	// Only the control word may change while the block runs
	assign wr_locked = run && awaddr_reg != `OFS_CTRL;

	// Write address channel; address and data may come in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			awaddr_reg <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end else if (!aw_held && !s_axi_bvalid) begin
			s_axi_awready <= 1'b1;
		end
	end

	// Write data channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			wdata_reg <= s_axi_wdata;
			wstrb_reg <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end else if (!w_held && !s_axi_bvalid) begin
			s_axi_wready <= 1'b1;
		end
	end

	// Write response; unmapped or locked words answer SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wr_known && !wr_locked) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Block-wide configuration words
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= `CTRL_RST;
			clkgen_reg <= `CLKGEN_RST;
			sel_lo_reg <= `SEL_RST;
			sel_hi_reg <= `SEL_RST;
		end else if (wr_fire && !wr_locked) begin
			unique case (awaddr_reg)
				`OFS_CTRL: ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg) & `CTRL_MASK;
				`OFS_CLKGEN: clkgen_reg <= merge(clkgen_reg, wdata_reg, wstrb_reg);
				`OFS_SEL_LO: sel_lo_reg <= merge(sel_lo_reg, wdata_reg, wstrb_reg) & `SEL_MASK;
				`OFS_SEL_HI: sel_hi_reg <= merge(sel_hi_reg, wdata_reg, wstrb_reg) & `SEL_MASK;
				default: ;
			endcase
		end
	end

	// Per-cell configuration words, one per aligned word of the page
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 16; i++) begin
				cell_cfg_reg[i] <= `CELL_CFG_RST;
			end
		end else if (wr_fire && !wr_locked && wr_is_cell) begin
			cell_cfg_reg[awaddr_reg[5:2]] <= merge(cell_cfg_reg[awaddr_reg[5:2]],
				wdata_reg, wstrb_reg) & `CELL_CFG_MASK;
		end
	end

	// Read decode for one word
	function automatic logic [31:0] read_word(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h00000000;
		if (a[7:6] == `CELL_CFG_PAGE && a[1:0] == 2'h0) begin
			v = cell_cfg_reg[a[5:2]];
		end else begin
			unique case (a)
				`OFS_CTRL: v = ctrl_reg;
				`OFS_CLKGEN: v = clkgen_reg;
				`OFS_SEL_LO: v = sel_lo_reg;
				`OFS_SEL_HI: v = sel_hi_reg;
				`OFS_CELL_STATE: v = {16'h0000, cell_q};
				`OFS_PIN_STATE: v = {28'h0000000, global_routing_pool_clk};
				default: v = 32'h00000000;
			endcase
		end
		return v;
	endfunction

	// Read channel; the answer comes one cycle after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= read_word(s_axi_araddr);
			s_axi_rresp <= (s_axi_araddr[7:6] == `CELL_CFG_PAGE ||
				s_axi_araddr <= `OFS_PIN_STATE) && s_axi_araddr[1:0] == 2'h0 ?
				`RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Global clocks and block clock generator

	logic [3:0] blk_clk, blk_clk_prev_reg, blk_tick;
	logic sh_clk, sh_init;

	// Pins are handed to the routing pool as plain inputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			global_routing_pool_clk <= 4'h0;
		end else begin
			global_routing_pool_clk <= gclk_pin;
		end
	end

	// Each block clock is the OR of chosen pins, each true or inverted
	for (genvar k = 0; k < 4; k++) begin : g_blk_clk
		blk_clk_cfg_t cfg;
		assign cfg = clkgen_reg[8*k +: 8];
		assign blk_clk[k] = |(cfg.en & (gclk_pin ^ cfg.inv));
	end

	// Cells act on rising edges of their block clock, seen in aclk time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			blk_clk_prev_reg <= 4'h0;
		end else begin
			blk_clk_prev_reg <= blk_clk;
		end
	end
	assign blk_tick = blk_clk & ~blk_clk_prev_reg;

	// Shared terms pass an optional inverter before reaching the cells
	assign sh_clk = shared_term_clock ^ ctrl_reg[`CTRL_SCLK_INV_BIT];
	assign sh_init = shared_term_init ^ ctrl_reg[`CTRL_SINIT_INV_BIT];

	////////////////////////////////////////////////////////////////////
	// Register cells

	for (genvar i = 0; i < 16; i++) begin : g_cell
		cell_cfg_t cfg;
		cell_ctl_t ctl;
		logic ce, set_src, rst_src, blk_set, blk_rst;

		assign cfg = cell_cfg_reg[i];

		// Clock enable selector
		always_comb begin
			unique case (cfg.ce_sel)
				CE_INDIV: ce = indiv_init_or_clk_en_term[i];
				CE_INDIV_INV: ce = ~indiv_init_or_clk_en_term[i];
				CE_SHARED_CLK: ce = sh_clk;
				CE_HIGH: ce = 1'b1;
			endcase
		end

		// Block init term reaches a cell as set or as reset only in mode INIT_SET or INIT_RESET
		assign blk_set = cfg.mode == INIT_SET && sh_init;
		assign blk_rst = cfg.mode == INIT_RESET && sh_init;

		// Own two terms are stolen only when enabled for this cell
		assign set_src = blk_set || (cfg.indiv_en && indiv_set_term[i]);
		assign rst_src = blk_rst || (cfg.indiv_en && indiv_reset_term[i]);

		// Swap exchanges the two sources, and the power-up state with them
		assign ctl.set = cfg.swap ? rst_src : set_src;
		assign ctl.rst = cfg.swap ? set_src : rst_src;
		assign ctl.pwrup_set = cfg.swap ? cfg.mode == INIT_RESET :
			cfg.mode == INIT_SET;
		assign ctl.ce = ce;
		assign ctl.tick = blk_tick[cfg.clk_sel];
		assign ctl.d = cell_d[i];

		// Cells hold their power-up state until run, standing in for the
		// still clocks the surroundings must provide after power-up
		cell_register u_cell (
			.aclk(aclk),
			.aresetn(aresetn),
			.run(run),
			.ctl(ctl),
			.q(cell_q[i])
		);
	end

	////////////////////////////////////////////////////////////////////
	// Output routing pool

	logic [63:0] slice_sel;

	assign slice_sel = {sel_hi_reg, sel_lo_reg};

	// First cell of each slice's window for the chosen slice count
	function automatic logic [3:0] window_start(input int unsigned k);
		int unsigned s;
		unique case (SLICES)
			8: s = 2 * k;
			12: s = k + k / 3;
			default: s = k;
		endcase
		return s[3:0];
	endfunction

	// One slice per I/O cell; enable rides beside the data
	for (genvar k = 0; k < SLICES; k++) begin : g_slice
		routing_slice #(
			.START(window_start(k))
		) u_slice (
			.aclk(aclk),
			.aresetn(aresetn),
			.cell_q(cell_q),
			.cell_oe(cell_oe_term),
			.sel(slice_sel[4*k +: 3]),
			.pin_out(io_out[k]),
			.pin_oe(io_oe[k])
		);
	end

endmodule // macrocell_ctrl_output_routing

`default_nettype wire

/* File: pkg/macrocell_map.svh */
// Register offsets, field positions and reset values of the block.
// Assumes inclusion by bare name from any file that needs them.
`ifndef MACROCELL_MAP_SVH
`define MACROCELL_MAP_SVH

// Byte offsets on the register bus
`define OFS_CTRL 8'h00
`define OFS_CLKGEN 8'h04
`define OFS_SEL_LO 8'h08
`define OFS_SEL_HI 8'h0c
`define OFS_CELL_STATE 8'h10
`define OFS_PIN_STATE 8'h14
`define CELL_CFG_PAGE 2'h1

// Control word fields
`define CTRL_RUN_BIT 0
`define CTRL_SCLK_INV_BIT 1
`define CTRL_SINIT_INV_BIT 2
`define CTRL_MASK 32'h00000007

// Reset values
`define CTRL_RST 32'h00000000
`define CLKGEN_RST 32'h08040201
`define SEL_RST 32'h00000000
`define CELL_CFG_RST 32'h00000000

// Read-back masks for fields with reserved bits
`define SEL_MASK 32'h77777777
`define CELL_CFG_MASK 32'h000000ff

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: pkg/macrocell_pkg.sv */
// Types shared by the register cells, routing slices and the top.
// Assumes nothing of its surroundings.
`default_nettype none

package macrocell_pkg;

	// Clock enable source, in selector order
	typedef enum logic [1:0] {CE_INDIV, CE_INDIV_INV, CE_SHARED_CLK, CE_HIGH} ce_sel_t;

	// What the block-level init term does to a cell
	typedef enum logic [1:0] {INIT_NONE, INIT_SET, INIT_RESET, INIT_RSVD} init_mode_t;

	// Per-cell configuration word
	typedef struct packed {
		logic [23:0] unused;
		logic swap;
		logic indiv_en;
		init_mode_t mode;
		logic [1:0] clk_sel;
		ce_sel_t ce_sel;
	} cell_cfg_t;

	// Per block clock: which global clocks, and which of them inverted
	typedef struct packed {
		logic [3:0] inv;
		logic [3:0] en;
	} blk_clk_cfg_t;

	// Everything a register cell needs in one cycle
	typedef struct packed {
		logic set;
		logic rst;
		logic ce;
		logic tick;
		logic pwrup_set;
		logic d;
	} cell_ctl_t;

endpackage

`default_nettype wire

/* File: logic/cell_register.sv */
// One register cell with init and power-up handling.
// Assumes its control bundle is built in the same clock domain.
`default_nettype none

module cell_register (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Block state and controls
	input wire logic run,
	input wire macrocell_pkg::cell_ctl_t ctl,
	// Register value
	output logic q
);
	import macrocell_pkg::*;

	// Set/reset act on any edge, not only on a cell clock tick;
	// reset wins when both are asserted together
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= 1'b0;
		end else if (!run) begin
			q <= ctl.pwrup_set;
		end else if (ctl.rst) begin
			q <= 1'b0;
		end else if (ctl.set) begin
			q <= 1'b1;
		end else if (ctl.tick && ctl.ce) begin
			q <= ctl.d;
		end
	end

endmodule // cell_register

`default_nettype wire

/* File: logic/routing_slice.sv */
// One output routing slice: an 8-wide window over the 16 cells.
// Assumes selects are static while the block runs.
`default_nettype none

module routing_slice #(
	parameter logic [3:0] START = 4'h0
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Cell outputs and their local enable terms
	input wire logic [15:0] cell_q,
	input wire logic [15:0] cell_oe,
	input wire logic [2:0] sel,
	// Toward the I/O cell
	output logic pin_out,
	output logic pin_oe
);
	import macrocell_pkg::*;

	logic [3:0] pick;

	// Window wraps modulo 16 by the 4-bit sum
	assign pick = START + {1'b0, sel};

	// The enable follows the very cell chosen for the data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_out <= 1'b0;
			pin_oe <= 1'b0;
		end else begin
			pin_out <= cell_q[pick];
			pin_oe <= cell_oe[pick];
		end
	end

endmodule // routing_slice

`default_nettype wire

/* File: verification/macrocell_ctrl_output_routing_properties.sv */
// Port-level assertions for the control and output routing block.
// Assumes it is bound to the top module and sees only its ports.
`default_nettype none

module routing_checker #(
	parameter int unsigned SLICES = 16
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Logic side
	input wire logic [3:0] gclk_pin,
	input wire logic [15:0] cell_oe_term,
	input wire logic [3:0] global_routing_pool_clk,
	input wire logic [15:0] cell_q,
	input wire logic [SLICES-1:0] io_out,
	input wire logic [SLICES-1:0] io_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	////////////////////////////////////////////////////////////////////////////////
	// Slice 0 window is cells 0..7 in every variant, so it needs no config view
	grp_clk_copy_a: assert property ($past(aresetn) |-> global_routing_pool_clk == $past(gclk_pin))
		else $error("global pool clock copy wrong");
	reset_clear_a: assert property (!$past(aresetn) |-> cell_q == 16'h0000 && io_out == '0)
		else $error("outputs not cleared by reset");
	slice_low_a: assert property ($past(aresetn) && $past(cell_q[7:0]) == 8'h00 |-> !io_out[0])
		else $error("slice 0 drives a cell outside its window");
	slice_high_a: assert property ($past(aresetn) && $past(cell_q[7:0]) == 8'hff |-> io_out[0])
		else $error("slice 0 misses its window");
	oe_window_a: assert property ($past(aresetn, 2) && $past(aresetn) && $past(cell_oe_term[7:0]) == 8'h00
		&& $past(cell_oe_term[7:0], 2) == 8'h00 |-> !io_oe[0])
		else $error("slice 0 enable outside its window");
	b_latency_a: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
		else $error("write answer late");
	b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1 s_axi_awready && s_axi_wready)
		else $error("write channel not reopened");
	ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready)
		else $error("read channel not reopened");

	// Main scenarios reached
	cov_write: cover property (s_axi_bvalid && s_axi_bready);
	cov_read: cover property (s_axi_rvalid && s_axi_rready);
	cov_route: cover property ($rose(io_out[0]));
endmodule // routing_checker

bind macrocell_ctrl_output_routing routing_checker #(.SLICES(SLICES)) routing_checker_inst (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .gclk_pin(gclk_pin),
	.cell_oe_term(cell_oe_term), .global_routing_pool_clk(global_routing_pool_clk),
	.cell_q(cell_q), .io_out(io_out), .io_oe(io_oe));

`default_nettype wire

/* File: verification/io_pads.sv */
// Pad model at the far side of the routing pool.
// Assumes an undriven pad settles at its default pull-down.
`default_nettype none

module io_pads #(
	parameter int unsigned N = 16
) (
	// From the routing slices
	input wire logic [N-1:0] io_out,
	input wire logic [N-1:0] io_oe,
	// Pin levels
	output logic [N-1:0] pad
);
	timeunit 1ns;
	timeprecision 1ps;
	// Released pads fall to the pull-down, never keep the last value
	assign pad = io_out & io_oe;
endmodule // io_pads

`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the control and output routing block.
// Assumes the package, design, checker and pad model are compiled first.
`default_nettype none
`include "macrocell_map.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, sclk, sinit;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] gclk, pool_clk;
	logic [1:0] bresp, rresp;
	logic [15:0] ce_t, set_t, rst_t, oe_t, d, q, io_o, io_e, pad;
	int num_errors, compares, k;
	// Cells 0-2 test init modes and swap, 4-7 the enable sources, 8-9 own set/reset
	localparam logic [7:0] CFG [16] = '{8'h13, 8'ha3, 8'h93, 8'h03, 8'h00, 8'h01, 8'h02, 8'h03,
		8'h43, 8'h43, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03};
	localparam logic [31:0] LO = 32'h00000007;
	localparam logic [31:0] HI = 32'h10000000;

	macrocell_ctrl_output_routing macrocell_ctrl_output_routing_inst (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.gclk_pin(gclk), .indiv_init_or_clk_en_term(ce_t), .indiv_set_term(set_t),
		.indiv_reset_term(rst_t), .cell_oe_term(oe_t), .shared_term_clock(sclk),
		.shared_term_init(sinit), .cell_d(d), .global_routing_pool_clk(pool_clk), .cell_q(q),
		.io_out(io_o), .io_oe(io_e));
	io_pads io_pads_inst (.io_out(io_o), .io_oe(io_e), .pad(pad));

	////////////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		wrap_up();
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Bus write; each channel is released at the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		int n;
		n = 0;
		// An edge passes first, so back-to-back calls never drive bready twice in one step
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 50);
		bready <= 1'b0;
		if (!bvalid) begin
			num_errors++;
			wrap_up();
		end
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
		int n;
		n = 0;
		// Same spacing as the write, for rready
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 50);
		rready <= 1'b0;
		if (!rvalid) begin
			num_errors++;
			wrap_up();
		end
		chk(rdata, ev);
		chk({30'h0, rresp}, {30'h0, er});
	endtask

	// Expected slice outputs from the select nibbles, wrapping over 16 cells
	function automatic logic [15:0] route(input logic [15:0] v);
		logic [63:0] s;
		s = {HI, LO};
		for (int i = 0; i < 16; i++)
			route[i] = v[(i + int'(s[4*i +: 3])) % 16];
	endfunction

	// One rising edge on global clock 0, then let q and the slices settle
	task automatic tick();
		gclk <= 4'h1;
		@(posedge aclk);
		gclk <= 4'h0;
		repeat (3) @(posedge aclk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence; clocks stay still until configuration is done
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, sclk, sinit} = '0;
		{awaddr, araddr, wdata, gclk, ce_t, set_t, rst_t, oe_t, d} = '0;
		num_errors = 0;
		compares = 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`OFS_CTRL, `CTRL_RST, `RESP_OKAY);
		rd(`OFS_CLKGEN, `CLKGEN_RST, `RESP_OKAY);
		rd(8'h40, `CELL_CFG_RST, `RESP_OKAY);
		rd(8'h3c, 32'h0, `RESP_SLVERR);
		for (k = 0; k < 16; k++)
			wr(8'h40 + 8'(4 * k), {24'h0, CFG[k]}, `RESP_OKAY);
		wr(`OFS_SEL_LO, LO, `RESP_OKAY);
		wr(`OFS_SEL_HI, HI, `RESP_OKAY);
		rd(`OFS_SEL_HI, HI, `RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk({16'h0, q}, 32'h0003);
		rd(`OFS_CELL_STATE, 32'h0003, `RESP_OKAY);
		wr(`OFS_CTRL, 32'h1, `RESP_OKAY);
		wr(`OFS_CLKGEN, 32'h0, `RESP_SLVERR);
		rd(`OFS_CLKGEN, `CLKGEN_RST, `RESP_OKAY);
		// Enable sources: term low, so only the inverted-term cell and fixed-high cells load
		// Cell 7 high so slice 0 really shows the far end of its window
		d <= 16'h5abc;
		oe_t <= 16'hf0f0;
		tick();
		chk({16'h0, q}, 32'h5aac);
		chk({16'h0, io_o}, {16'h0, route(16'h5aac)});
		chk({16'h0, io_e}, {16'h0, route(16'hf0f0)});
		chk({16'h0, pad}, {16'h0, route(16'h5aac) & route(16'hf0f0)});
		// Block init pulse: set cells, swapped cells do the opposite
		sinit <= 1'b1;
		@(posedge aclk);
		sinit <= 1'b0;
		repeat (3) @(posedge aclk);
		chk({16'h0, q}, 32'h5aab);
		// Own terms act without a tick; reset beats set
		set_t <= 16'h0300;
		rst_t <= 16'h0200;
		repeat (3) @(posedge aclk);
		chk({16'h0, q}, 32'h59ab);
		set_t <= 16'h0000;
		rst_t <= 16'h0000;
		// Inverted shared clock as enable, term now high
		wr(`OFS_CTRL, 32'h3, `RESP_OKAY);
		ce_t <= 16'h0010;
		d <= 16'h0050;
		tick();
		chk({16'h0, q}, 32'h0050);
		wrap_up();
	end
endmodule // tb_top

`default_nettype wire
